// ===== verilog/cie_pkg.sv
// Constants and types for the CPU interrupt entry and exit unit
// Contract
// - Reset and each source own low vector
// - Take only with individual and global enable
// - Boot lock bits suppress interrupts by PC
// - Vector select bit moves table to boot
// - Reset fuse moves reset vector to boot
// - Entry clears global enable; software may renest
// - Vectoring clears the flag of flag sources
// - Writing one clears a flag, zero keeps
// - Disabled flag source sets and holds flag
// - Flags held while disabled, served by priority
// - Level sources request only while present
// - One instruction runs after return before service
// - Status flags never saved or restored
// - Clear-enable instruction blocks interrupts at once
// - One instruction runs after set-enable instruction
// - Entry takes five cycles, pushing PC
// - Vector jump completes in three cycles
// - Multi-cycle instruction completes before service
// - Wake from sleep adds five cycles
// - Return: five cycles, pop three, set enable
// - Core runs undivided from the chip clock
// - Entry push decrements stack pointer by three
// - Global enable sits at status bit 7
package cie_pkg;

    localparam int          NSRC           = 8;
    localparam logic [7:0]  LEVEL_SRC_MASK = 8'hC0;     // Sources 6 and 7 are level type
    localparam logic [15:0] BOOT_START     = 16'h3800;  // Word address of boot section
    localparam logic [15:0] VEC_APP_BASE   = 16'h0000;

    // Timing counts in CPU clocks, then byte counts of the PC push
    localparam logic [3:0]  ENTRY_CYC      = 4'h5;
    localparam logic [3:0]  WAKE_CYC       = 4'h5;
    localparam logic [3:0]  JUMP_CYC       = 4'h3;
    localparam logic [3:0]  RET_CYC        = 4'h5;
    localparam logic [3:0]  PC_BYTES       = 4'h3;
    localparam logic [15:0] PUSH_DEPTH     = 16'h0003;

    // APB byte offsets
    localparam logic [11:0] OFS_STATUS     = 12'h000;   // status_flags_reg
    localparam logic [11:0] OFS_ENABLE     = 12'h004;
    localparam logic [11:0] OFS_FLAGS      = 12'h008;
    localparam logic [11:0] OFS_MCU        = 12'h00C;   // mcu_control_reg
    localparam logic [11:0] OFS_SP         = 12'h010;
    localparam logic [11:0] OFS_STATE      = 12'h014;

    // Field positions
    localparam int          GIE_BIT        = 7;
    localparam int          VEC_BOOT_BIT   = 1;

    // Reset values
    localparam logic [7:0]  STATUS_RST     = 8'h00;
    localparam logic [7:0]  ENABLE_RST     = 8'h00;
    localparam logic [7:0]  MCU_RST        = 8'h00;
    localparam logic [15:0] SP_RST         = 16'h0AFF;

    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_JUMP, ST_RETURN} cie_state_t;

endpackage

// ===== verilog/cie_top.sv
// CPU interrupt entry and exit unit with APB register access
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cie_top
    import cie_pkg::*;
(
    input  wire logic        MCLK,                      // CPU clock, 40 MHz, undivided
    input  wire logic        RST,                       // Sync reset, active high
    input  wire logic        PSEL,                      // APB select
    input  wire logic        PENABLE,                   // APB access phase
    input  wire logic        PWRITE,                    // APB direction
    input  wire logic [11:0] PADDR,                     // APB byte address
    input  wire logic [31:0] PWDATA,                    // APB write data
    output logic      [31:0] PRDATA,                    // APB read data
    output logic             PREADY,                    // APB ready
    output logic             PSLVERR,                   // APB error, unmapped
    input  wire logic [7:0]  SRC_IN,                    // Source events and levels
    input  wire logic        INSTR_BOUNDARY,            // Instruction completes
    input  wire logic        SET_GLOBAL_ENABLE_INSTR,   // Set-enable executed
    input  wire logic        CLEAR_GLOBAL_ENABLE_INSTR, // Clear-enable executed
    input  wire logic        RETURN_FROM_IRQ_INSTR,     // Return decoded
    input  wire logic        SLEEPING,                  // Core in sleep mode
    input  wire logic [15:0] PC_IN,                     // Current program counter
    input  wire logic [15:0] JMP_TARGET,                // Target of vector jump
    input  wire logic [7:0]  STK_RDATA,                 // Stack read data
    input  wire logic        BOOT_LOCK_BIT_APP,         // Pin, lock programmed
    input  wire logic        BOOT_LOCK_BIT_BOOT,        // Pin, lock programmed
    input  wire logic        RESET_VECTOR_BOOT_FUSE,    // Pin, fuse programmed
    output logic             HOLD,                      // Sequencer stalled
    output logic             PC_LOAD,                   // Load PC_NEW pulse
    output logic      [15:0] PC_NEW,                    // New program counter
    output logic             STK_WE,                    // Stack write strobe
    output logic             STK_RE,                    // Stack read strobe
    output logic      [15:0] STK_ADDR,                  // Stack address
    output logic      [7:0]  STK_WDATA,                 // Stack write data
    output logic             IRQ_ACK,                   // Interrupt taken pulse
    output logic      [2:0]  IRQ_ID,                    // Taken source index
    output logic             GIE,                       // Global enable
    output logic      [15:0] RESET_VEC                  // Reset vector address
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Lowest index wins, as it has the lowest vector address
    function automatic logic [2:0] first_set(input logic [7:0] r);
        logic [2:0] f;
        f = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (r[i]) begin
                f = i[2:0];
            end
        end
        return f;
    endfunction

    function automatic logic in_boot(input logic [15:0] pc);
        return pc >= BOOT_START;
    endfunction

    function automatic logic [15:0] vec_addr(input logic [15:0] base, input logic [2:0] id);
        logic [3:0] slot;
        slot = {1'b0, id} + 4'h1;
        return base + {11'h000, slot, 1'b0};
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************

    logic [7:0]  stat_ff;
    logic [7:0]  en_ff;
    logic [7:0]  flag_ff;
    logic [7:0]  mcu_ff;
    logic [15:0] sp_ff;
    cie_state_t  st_ff;
    cie_state_t  nxt_st;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic [3:0]  len_ff;
    logic        skip_ff;
    logic [15:0] vec_ff;
    logic [15:0] pcsv_ff;
    logic [15:0] pop_ff;
    logic [2:0]  pin_s1_ff;
    logic [2:0]  pin_s2_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        hold_ff;
    logic        pcload_ff;
    logic [15:0] pcnew_ff;
    logic        stkwe_ff;
    logic        stkre_ff;
    logic [15:0] stkaddr_ff;
    logic [7:0]  stkwd_ff;
    logic        ack_ff;
    logic [2:0]  id_ff;
    logic [15:0] rstvec_ff;

    logic        setup;
    logic        wr_go;
    logic        gie;
    logic        vector_table_boot_select;
    logic [7:0]  req;
    logic        suppress;
    logic        take;
    logic [2:0]  take_id;
    logic [7:0]  w1c;
    logic [7:0]  take_clr;
    logic        entry_end;
    logic        jump_end;
    logic        ret_end;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************

    // Lock and fuse pins come from outside the clock domain
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {RESET_VECTOR_BOOT_FUSE, BOOT_LOCK_BIT_BOOT, BOOT_LOCK_BIT_APP};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ************************************************************
    // Request selection
    // ************************************************************

    // Level sources bypass the flags and vanish with their condition
    assign gie     = stat_ff[GIE_BIT];
    assign vector_table_boot_select = mcu_ff[VEC_BOOT_BIT];
    assign req     = ((flag_ff & ~LEVEL_SRC_MASK) | (SRC_IN & LEVEL_SRC_MASK)) & en_ff;
    assign take_id = first_set(req);

    // Locked section may not be interrupted by the other section's table
    assign suppress = (pin_s2_ff[1] & ~vector_table_boot_select & in_boot(PC_IN))
                    | (pin_s2_ff[0] & vector_table_boot_select & ~in_boot(PC_IN));

    // Only at a boundary or in sleep, so multi-cycle instructions finish first
    assign take = (st_ff == ST_IDLE) && (INSTR_BOUNDARY || SLEEPING)
                && gie && (req != 8'h00)
                && !CLEAR_GLOBAL_ENABLE_INSTR
                && !RETURN_FROM_IRQ_INSTR && !skip_ff && !suppress;

    // ************************************************************
    // APB slave
    // ************************************************************

    assign setup = PSEL && !PENABLE;
    assign wr_go = PSEL && PENABLE && pready_ff && PWRITE;

    // One wait-free access cycle; data captured at setup
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            if (setup) begin
                unique case (PADDR)
                    OFS_STATUS: prdata_ff <= {24'h000000, stat_ff};
                    OFS_ENABLE: prdata_ff <= {24'h000000, en_ff};
                    OFS_FLAGS:  prdata_ff <= {24'h000000, flag_ff};
                    OFS_MCU:    prdata_ff <= {24'h000000, mcu_ff};
                    OFS_SP:     prdata_ff <= {16'h0000, sp_ff};
                    OFS_STATE:  prdata_ff <= {16'h0000, req, 2'h0, skip_ff, 1'b0, st_ff, hold_ff, 1'b0};
                    default:    pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Hardware writes after software so they win; never saved or restored
    always_ff @(posedge MCLK) begin
        if (RST) begin
            stat_ff <= STATUS_RST;
        end else begin
            if (wr_go && PADDR == OFS_STATUS) begin
                stat_ff <= PWDATA[7:0];
            end
            if (SET_GLOBAL_ENABLE_INSTR || ret_end) begin
                stat_ff[GIE_BIT] <= 1'b1;
            end
            if (CLEAR_GLOBAL_ENABLE_INSTR || take) begin
                stat_ff[GIE_BIT] <= 1'b0;
            end
        end
    end

    // Enables and control
    always_ff @(posedge MCLK) begin
        if (RST) begin
            en_ff  <= ENABLE_RST;
            mcu_ff <= MCU_RST;
        end else begin
            if (wr_go && PADDR == OFS_ENABLE) begin
                en_ff <= PWDATA[7:0];
            end
            if (wr_go && PADDR == OFS_MCU) begin
                mcu_ff <= PWDATA[7:0];
            end
        end
    end

    // Flags: set wins over both write-one clear and vectoring clear
    assign w1c      = (wr_go && PADDR == OFS_FLAGS) ? PWDATA[7:0] : 8'h00;
    assign take_clr = take ? (8'h01 << take_id) : 8'h00;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flag_ff <= 8'h00;
        end else begin
            flag_ff <= ((flag_ff & ~w1c & ~take_clr) | SRC_IN) & ~LEVEL_SRC_MASK;
        end
    end

    // Stack pointer; hardware push and pop override software writes
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sp_ff <= SP_RST;
        end else if (take) begin
            sp_ff <= sp_ff - PUSH_DEPTH;
        end else if (ret_end) begin
            sp_ff <= sp_ff + PUSH_DEPTH;
        end else if (wr_go && PADDR == OFS_SP) begin
            sp_ff <= PWDATA[15:0];
        end
    end

    // One instruction must run after set-enable or return
    always_ff @(posedge MCLK) begin
        if (RST) begin
            skip_ff <= 1'b0;
        end else if (SET_GLOBAL_ENABLE_INSTR || ret_end) begin
            skip_ff <= 1'b1;
        end else if (INSTR_BOUNDARY) begin
            skip_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Entry and exit sequencer
    // ************************************************************

    assign entry_end = (st_ff == ST_ENTRY) && (cnt_ff == len_ff - 4'h1);
    assign jump_end  = (st_ff == ST_JUMP) && (cnt_ff == JUMP_CYC - 4'h1);
    assign ret_end   = (st_ff == ST_RETURN) && (cnt_ff == RET_CYC - 4'h1);

    // Next state and count
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff + 4'h1;
        unique case (st_ff)
            ST_IDLE: begin
                nxt_cnt = 4'h0;
                if (take) begin
                    nxt_st = ST_ENTRY;
                end else if (RETURN_FROM_IRQ_INSTR) begin
                    nxt_st = ST_RETURN;
                end
            end
            ST_ENTRY: begin
                if (entry_end) begin
                    nxt_st  = ST_JUMP;
                    nxt_cnt = 4'h0;
                end
            end
            ST_JUMP: begin
                if (jump_end) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_RETURN: begin
                if (ret_end) begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_ff  <= ST_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Capture context at the moment of taking
    always_ff @(posedge MCLK) begin
        if (RST) begin
            len_ff  <= ENTRY_CYC;
            vec_ff  <= VEC_APP_BASE;
            pcsv_ff <= 16'h0000;
        end else if (take) begin
            len_ff  <= SLEEPING ? ENTRY_CYC + WAKE_CYC : ENTRY_CYC;
            vec_ff  <= vec_addr(vector_table_boot_select ? BOOT_START : VEC_APP_BASE,
                                take_id);
            pcsv_ff <= PC_IN;
        end
    end

    // Popped bytes: upper first and dropped, as PC is 16 bits wide
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pop_ff <= 16'h0000;
        end else if (st_ff == ST_RETURN && cnt_ff == 4'h2) begin
            pop_ff[15:8] <= STK_RDATA;
        end else if (st_ff == ST_RETURN && cnt_ff == 4'h3) begin
            pop_ff[7:0] <= STK_RDATA;
        end
    end

    // Stack strobes: three bytes each way, low byte pushed first
    always_ff @(posedge MCLK) begin
        if (RST) begin
            stkwe_ff   <= 1'b0;
            stkre_ff   <= 1'b0;
            stkaddr_ff <= 16'h0000;
            stkwd_ff   <= 8'h00;
        end else begin
            stkwe_ff <= (st_ff == ST_ENTRY) && (cnt_ff < PC_BYTES);
            stkre_ff <= (st_ff == ST_RETURN) && (cnt_ff < PC_BYTES);
            if (st_ff == ST_ENTRY) begin
                stkaddr_ff <= sp_ff + PUSH_DEPTH - {12'h000, cnt_ff};
            end else begin
                stkaddr_ff <= sp_ff + 16'h0001 + {12'h000, cnt_ff};
            end
            unique case (cnt_ff)
                4'h0:    stkwd_ff <= pcsv_ff[7:0];
                4'h1:    stkwd_ff <= pcsv_ff[15:8];
                default: stkwd_ff <= 8'h00;
            endcase
        end
    end

    // Program counter loads: vector, then jump target, or popped return
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pcload_ff <= 1'b0;
            pcnew_ff  <= 16'h0000;
            hold_ff   <= 1'b0;
            ack_ff    <= 1'b0;
            id_ff     <= 3'h0;
        end else begin
            pcload_ff <= entry_end || jump_end || ret_end;
            if (entry_end) begin
                pcnew_ff <= vec_ff;
            end else if (jump_end) begin
                pcnew_ff <= JMP_TARGET;
            end else if (ret_end) begin
                pcnew_ff <= pop_ff;
            end
            hold_ff <= nxt_st != ST_IDLE;
            ack_ff  <= take;
            if (take) begin
                id_ff <= take_id;
            end
        end
    end

    // Reset vector follows the fuse, caught after reset release
    always_ff @(posedge MCLK) begin
        if (RST) begin
            rstvec_ff <= VEC_APP_BASE;
        end else begin
            rstvec_ff <= pin_s2_ff[2] ? BOOT_START : VEC_APP_BASE;
        end
    end

    // Every output straight from a flip-flop; one clock, no divider
    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign HOLD      = hold_ff;
    assign PC_LOAD   = pcload_ff;
    assign PC_NEW    = pcnew_ff;
    assign STK_WE    = stkwe_ff;
    assign STK_RE    = stkre_ff;
    assign STK_ADDR  = stkaddr_ff;
    assign STK_WDATA = stkwd_ff;
    assign IRQ_ACK   = ack_ff;
    assign IRQ_ID    = id_ff;
    assign GIE       = stat_ff[GIE_BIT];
    assign RESET_VEC = rstvec_ff;

    // ************************************************************
    // Assertions
    // ************************************************************

    // Helper: high from a return until the next instruction completes
    logic ret_gap_ff;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ret_gap_ff <= 1'b0;
        end else begin
            ret_gap_ff <= (st_ff == ST_RETURN) || (ret_gap_ff && !INSTR_BOUNDARY);
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    AST_CLEAR_BLOCKS: assert property (CLEAR_GLOBAL_ENABLE_INSTR |-> !take)
        else $error("interrupt taken with clear-enable");
    AST_GATED: assert property (take |-> gie && en_ff[take_id])
        else $error("interrupt taken while disabled");
    AST_ENTRY_GIE: assert property (take |=> !gie && HOLD)
        else $error("global enable not cleared on entry");
    AST_FLAG_CLR: assert property (take && !LEVEL_SRC_MASK[take_id] && !SRC_IN[take_id]
        |=> !flag_ff[$past(take_id)])
        else $error("flag not cleared on vectoring");
    AST_ENTRY_FIVE: assert property (take && !SLEEPING
        |=> !PC_LOAD [*5] ##1 (PC_LOAD && PC_NEW == vec_ff))
        else $error("vector not loaded after five cycles");
    AST_WAKE_TEN: assert property (take && SLEEPING |-> ##11 PC_LOAD)
        else $error("wake entry not ten cycles");
    AST_JUMP_THREE: assert property (take && !SLEEPING |-> ##9 PC_LOAD)
        else $error("vector jump not three cycles");
    AST_SP_DOWN: assert property (take |=> sp_ff == $past(sp_ff) - PUSH_DEPTH)
        else $error("stack pointer not lowered by three");
    AST_RET_FIVE: assert property (RETURN_FROM_IRQ_INSTR && st_ff == ST_IDLE && !take
        |-> ##6 (PC_LOAD && gie && sp_ff == $past(sp_ff, 6) + PUSH_DEPTH))
        else $error("return not five cycles");
    AST_ONE_AFTER: assert property (ret_gap_ff && st_ff == ST_IDLE |-> !take)
        else $error("no instruction between return and entry");

endmodule // cie_top
`default_nettype wire

// ===== sim/cie_stack_model.sv
// Stack memory model beside the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module cie_stack_model (
    input  wire logic        MCLK,      // CPU clock
    input  wire logic        STK_WE,    // Byte write strobe
    input  wire logic        STK_RE,    // Byte read strobe
    input  wire logic [15:0] STK_ADDR,  // Byte address
    input  wire logic [7:0]  STK_WDATA, // Write data
    output logic      [7:0]  STK_RDATA  // Read data, same cycle
);
    logic [7:0] mem_ff [0:4095];
    // Pushed bytes land on the clock edge
    always @(posedge MCLK) begin
        if (STK_WE) begin
            mem_ff[STK_ADDR[11:0]] <= STK_WDATA;
        end
    end
    // Outside a read the lines move, so a stray sample cannot pass
    assign STK_RDATA = STK_RE ? mem_ff[STK_ADDR[11:0]] : ~STK_ADDR[7:0];
endmodule // cie_stack_model
`default_nettype wire

// ===== sim/cie_top_tb.sv
// Self-checking bench of the interrupt entry and exit unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module cie_top_tb
    import cie_pkg::*;
;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        bnd = 1'b0, seti = 1'b0, clri = 1'b0, rtn = 1'b0, slp = 1'b0;
    logic        lck_a = 1'b0, lck_b = 1'b0, fuse = 1'b1;
    logic        pready, perr, hold, pcl, swe, sre, ack, gie;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  src = 8'h00, srd, swd;
    logic [15:0] pc = 16'h0000, jt = 16'h0000, pcn, sadr, rvec, spc;
    logic [2:0]  aid;
    int          n_fail = 0, num_checks = 0;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    cie_top cie_top_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
        .SRC_IN(src), .INSTR_BOUNDARY(bnd), .SET_GLOBAL_ENABLE_INSTR(seti),
        .CLEAR_GLOBAL_ENABLE_INSTR(clri), .RETURN_FROM_IRQ_INSTR(rtn), .SLEEPING(slp),
        .PC_IN(pc), .JMP_TARGET(jt), .STK_RDATA(srd), .BOOT_LOCK_BIT_APP(lck_a),
        .BOOT_LOCK_BIT_BOOT(lck_b), .RESET_VECTOR_BOOT_FUSE(fuse), .HOLD(hold),
        .PC_LOAD(pcl), .PC_NEW(pcn), .STK_WE(swe), .STK_RE(sre), .STK_ADDR(sadr),
        .STK_WDATA(swd), .IRQ_ACK(ack), .IRQ_ID(aid), .GIE(gie), .RESET_VEC(rvec));
    cie_stack_model cie_stack_model_i (.MCLK(mclk), .STK_WE(swe), .STK_RE(sre),
        .STK_ADDR(sadr), .STK_WDATA(swd), .STK_RDATA(srd));

    // Vector of a source: two words per slot, slot zero is reset
    function automatic logic [15:0] vec(input logic [2:0] id, input logic boot);
        return (boot ? BOOT_START : VEC_APP_BASE) + {12'h000, id, 1'b0} + 16'h0002;
    endfunction

    // One APB transfer; waits for ready, never assumes a cycle count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic err);
        @(posedge mclk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        if (!wr) `CHK(prdata, exp)
        `CHK(perr, err)
        {psel, pen} <= 2'b00;
    endtask

    // One-cycle source event
    task automatic pulse(input logic [7:0] v);
        @(posedge mclk);
        src <= v;
        @(posedge mclk);
        src <= 8'h00;
    endtask

    // Boundary or wake with random PC; checks refusal or the full entry timing
    task automatic take(input logic hit, input logic [2:0] id, input logic boot,
                        input logic sl, input logic cl, input logic st);
        @(posedge mclk);
        pc <= lck_a ? 16'($urandom % BOOT_START) : 16'($urandom); // App PC while locked
        jt <= 16'($urandom);
        {bnd, slp, clri, seti} <= {~sl, sl, cl, st};
        @(posedge mclk);
        if (hit) spc = pc;
        {bnd, slp, clri, seti} <= 4'h0;
        #1;
        `CHK(ack, hit)
        if (hit) begin
            `CHK({aid, gie}, {id, 1'b0})
            repeat (sl ? 10 : 5) @(posedge mclk);
            #1;
            `CHK({pcl, pcn}, {1'b1, vec(id, boot)})
            repeat (3) @(posedge mclk);
            #1;
            `CHK({pcl, hold, pcn}, {2'b10, jt})
        end
    endtask

    // Return: popped PC and global enable after five cycles
    task automatic ret();
        @(posedge mclk);
        rtn <= 1'b1;
        @(posedge mclk);
        rtn <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        `CHK({pcl, gie, pcn}, {2'b11, spc})
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: registers, entries, returns, enable races
    initial begin
        void'($urandom(32'hEE71));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(rvec, BOOT_START) // Fuse moves reset vector
        apb(0, OFS_SP, 32'h0, {16'h0, SP_RST}, 0);
        apb(0, 12'h018, 32'h0, 32'h0, 1);
        pulse(8'h14);
        apb(0, OFS_FLAGS, 32'h0, 32'h14, 0); // Held while disabled
        apb(1, OFS_FLAGS, 32'h10, 32'h0, 0);
        apb(0, OFS_FLAGS, 32'h0, 32'h04, 0); // One clears, zero
        pulse(8'h10);
        apb(1, OFS_ENABLE, 32'h1C, 32'h0, 0);
        take(0, 0, 0, 0, 0, 0); // Global enable low
        apb(1, OFS_STATUS, {24'h0, 1'b1, 7'($urandom)}, 32'h0, 0);
        #1;
        `CHK(gie, 1'b1) // Status bit 7
        take(1, 2, 0, 0, 0, 0); // Lowest first
        apb(0, OFS_SP, 32'h0, {16'h0, SP_RST - PUSH_DEPTH}, 0); // Push lowers pointer
        apb(0, OFS_FLAGS, 32'h0, 32'h10, 0); // Flag cleared on vectoring
        ret(); // Pop and enable
        apb(0, OFS_SP, 32'h0, {16'h0, SP_RST}, 0); // Pointer restored
        apb(1, OFS_MCU, 32'h2, 32'h0, 0);
        take(0, 0, 0, 0, 0, 0); // One instruction after return
        take(1, 4, 1, 0, 0, 0); // Table in boot section
        ret();
        take(0, 0, 0, 0, 0, 0); // Uses up the instruction after return
        pulse(8'h08);
        take(0, 0, 0, 0, 1, 0); // Clear-enable wins same cycle
        `CHK(gie, 1'b0) // Enable cleared
        take(0, 0, 0, 0, 0, 1);
        take(0, 0, 0, 0, 0, 0); // One instruction after set-enable
        take(1, 3, 1, 1, 0, 0); // Wake adds five cycles
        ret();
        @(posedge mclk);
        lck_a <= 1'b1;
        pulse(8'h08);
        take(0, 0, 0, 0, 0, 0); // Instruction after return
        take(0, 0, 0, 0, 0, 0); // App lock refuses a PC outside the table
        @(posedge mclk);
        {rst, fuse, lck_a} <= 3'b100;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(rvec, VEC_APP_BASE) // Unprogrammed fuse keeps reset vector
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end
endmodule // cie_top_tb
`default_nettype wire
